// ### hdl/soc_object_ctrl.sv
// Control of one switchgear object: position decode, open/close pulses, supervision, statistics.
// Assumes synchronous inputs, a 250 MHz clock and a plain register port with one-cycle strobes.
`timescale 1ns/1ps
`include "soc_cfg.svh"

module soc_object_ctrl (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_din,
  input wire logic [7:0] i_logic,
  input wire logic [3:0] i_stage_start,
  input wire logic [3:0] i_stage_trip,
  input wire logic [3:0] i_stage_block,
  input wire logic i_app_open,
  input wire logic i_app_close,
  output logic [31:0] o_rdata,
  output logic o_open_cmd,
  output logic o_close_cmd,
  output logic [3:0] o_relay,
  output logic o_fail,
  output soc_pkg::soc_pos_t o_pos
);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  soc_pkg::soc_ctrl_t ctrl_reg;
  soc_pkg::soc_sel0_t sel0_reg;
  soc_pkg::soc_sel1_t sel1_reg;
  soc_pkg::soc_mask_t mask_reg;
  soc_pkg::soc_route_t [3:0] outcfg_reg;
  logic [31:0] trav_reg;
  logic [31:0] pulse_reg;
  logic [31:0] tmo_reg;
  logic cmd_wr;
  logic clr_stats;
  logic clr_rec;
  logic clr_lat;

  assign cmd_wr = i_wr && i_addr == `SOC_A_CMD;
  assign clr_stats = cmd_wr && i_wdata[`SOC_K_CLRST];
  assign clr_rec = cmd_wr && i_wdata[`SOC_K_CLRREC];
  assign clr_lat = cmd_wr && i_wdata[`SOC_K_CLRLAT];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg <= '{obj_type: soc_pkg::SOC_BREAKER, default: 1'b0};
      sel0_reg <= '0;
      sel1_reg <= '0;
      mask_reg <= '0;
      outcfg_reg <= '0;
      trav_reg <= `SOC_TRAV_CYC;
      pulse_reg <= `SOC_PULSE_CYC;
      tmo_reg <= `SOC_TMO_CYC;
    end else if (i_wr) begin
      unique case (i_addr)
        `SOC_A_CTRL: ctrl_reg <= i_wdata[$bits(soc_pkg::soc_ctrl_t)-1:0];
        `SOC_A_SEL0: sel0_reg <= i_wdata[$bits(soc_pkg::soc_sel0_t)-1:0];
        `SOC_A_SEL1: sel1_reg <= i_wdata[$bits(soc_pkg::soc_sel1_t)-1:0];
        `SOC_A_MASK: mask_reg <= i_wdata[$bits(soc_pkg::soc_mask_t)-1:0];
        `SOC_A_OUTCFG: outcfg_reg <= i_wdata[15:0];
        `SOC_A_TRAV: trav_reg <= i_wdata;
        `SOC_A_PULSE: pulse_reg <= i_wdata;
        `SOC_A_TMO: tmo_reg <= i_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Signal sources and position decode
  // ----------------------------------------
  soc_pkg::soc_pos_t pos_reg;
  soc_pkg::soc_pos_t raw_pos;
  logic [3:0] pos_hot;
  logic [31:0] src;
  logic [31:0] trav_cnt_reg;
  logic [1:0] rack_reg;

  // One selector index reaches inputs, logic signals, own status and other stages
  assign pos_hot = 4'h1 << pos_reg;
  assign src = {i_stage_block, i_stage_trip, i_stage_start, pos_hot, i_logic, i_din};
  assign o_pos = pos_reg;

  always_comb begin
    unique case ({src[sel0_reg.closed], src[sel0_reg.open]})
      2'b00: raw_pos = soc_pkg::SOC_POS_INTER;
      2'b01: raw_pos = soc_pkg::SOC_POS_OPEN;
      2'b10: raw_pos = soc_pkg::SOC_POS_CLOSED;
      2'b11: raw_pos = soc_pkg::SOC_POS_BAD;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pos_reg <= soc_pkg::SOC_POS_INTER;
      trav_cnt_reg <= '0;
    end else if (!ctrl_reg.enable) begin
      pos_reg <= soc_pkg::SOC_POS_INTER;
      trav_cnt_reg <= '0;
    end else if (raw_pos == soc_pkg::SOC_POS_INTER && trav_cnt_reg < trav_reg &&
                 (pos_reg == soc_pkg::SOC_POS_OPEN || pos_reg == soc_pkg::SOC_POS_CLOSED)) begin
      trav_cnt_reg <= trav_cnt_reg + 32'h1;
    end else begin
      pos_reg <= raw_pos;
      trav_cnt_reg <= '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rack_reg <= '0;
    end else if (ctrl_reg.enable && ctrl_reg.obj_type == soc_pkg::SOC_WD_BREAKER) begin
      rack_reg <= {src[sel0_reg.rk_out], src[sel0_reg.rk_in]};
    end else begin
      rack_reg <= '0;
    end
  end

  // ----------------------------------------
  // Request qualification
  // ----------------------------------------
  logic di_op_q;
  logic di_cl_q;
  logic di_op_rise;
  logic di_cl_rise;
  logic di_ok;
  logic bus_op;
  logic bus_cl;
  logic req_open;
  logic req_close;
  logic permit_close;
  logic blocked;
  logic start_open;
  logic start_close;
  soc_pkg::soc_state_t state_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      di_op_q <= 1'b0;
      di_cl_q <= 1'b0;
    end else begin
      di_op_q <= src[sel1_reg.di_open];
      di_cl_q <= src[sel1_reg.di_close];
    end
  end

  // A held input gives one request, not one per cycle
  assign di_op_rise = src[sel1_reg.di_open] && !di_op_q;
  assign di_cl_rise = src[sel1_reg.di_close] && !di_cl_q;
  assign di_ok = ctrl_reg.di_remote == ctrl_reg.remote;
  assign bus_op = cmd_wr && i_wdata[`SOC_K_OPEN];
  assign bus_cl = cmd_wr && i_wdata[`SOC_K_CLOSE];
  assign req_open = ctrl_reg.enable && (i_app_open || (di_ok && di_op_rise) || (ctrl_reg.remote && bus_op));
  assign req_close = ctrl_reg.enable && (i_app_close || (di_ok && di_cl_rise) || (ctrl_reg.remote && bus_cl));
  assign permit_close = (!ctrl_reg.use_sync || src[sel0_reg.sync]) && (!ctrl_reg.use_ready || src[sel0_reg.ready]);
  assign blocked = ctrl_reg.blk_en && src[sel1_reg.block];
  // Open wins over a simultaneous close
  assign start_open = state_reg == soc_pkg::SOC_IDLE && !blocked && req_open;
  assign start_close = state_reg == soc_pkg::SOC_IDLE && !blocked && req_close && !req_open && permit_close;

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  logic is_close_reg;
  logic [31:0] tmr_reg;
  logic at_target;
  logic done_ev;
  logic fail_ev;
  logic busy;

  assign busy = state_reg != soc_pkg::SOC_IDLE;
  assign at_target = pos_reg == (is_close_reg ? soc_pkg::SOC_POS_CLOSED : soc_pkg::SOC_POS_OPEN);
  assign done_ev = busy && at_target;
  assign fail_ev = busy && !at_target && tmr_reg >= tmo_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= soc_pkg::SOC_IDLE;
      is_close_reg <= 1'b0;
      tmr_reg <= '0;
      o_open_cmd <= 1'b0;
      o_close_cmd <= 1'b0;
    end else if (!ctrl_reg.enable) begin
      state_reg <= soc_pkg::SOC_IDLE;
      o_open_cmd <= 1'b0;
      o_close_cmd <= 1'b0;
    end else begin
      unique case (state_reg)
        soc_pkg::SOC_IDLE: begin
          if (start_open || start_close) begin
            state_reg <= soc_pkg::SOC_PULSE;
            is_close_reg <= start_close;
            tmr_reg <= '0;
            o_open_cmd <= start_open;
            o_close_cmd <= start_close;
          end
        end
        soc_pkg::SOC_PULSE, soc_pkg::SOC_WAIT: begin
          tmr_reg <= tmr_reg + 32'h1;
          if (done_ev || fail_ev) begin
            state_reg <= soc_pkg::SOC_IDLE;
            o_open_cmd <= 1'b0;
            o_close_cmd <= 1'b0;
          end else if (state_reg == soc_pkg::SOC_PULSE && tmr_reg + 32'h1 >= pulse_reg) begin
            state_reg <= soc_pkg::SOC_WAIT;
            o_open_cmd <= 1'b0;
            o_close_cmd <= 1'b0;
          end
        end
        default: state_reg <= soc_pkg::SOC_IDLE;
      endcase
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fail <= 1'b0;
    end else begin
      o_fail <= fail_ev || (o_fail && !(cmd_wr && i_wdata[`SOC_K_CLRFAIL]));
    end
  end

  // ----------------------------------------
  // Condition and statistics
  // ----------------------------------------
  soc_pkg::soc_cond_t cond_reg;
  soc_pkg::soc_cond_t cond_next;
  logic [6:0] cnt_inc;
  logic [15:0] cnt_reg [7];

  always_comb begin
    if (blocked) begin
      cond_next = soc_pkg::SOC_BLOCKED;
    end else if (fail_ev) begin
      cond_next = soc_pkg::SOC_TRIP;
    end else if (busy) begin
      cond_next = soc_pkg::SOC_START;
    end else begin
      cond_next = soc_pkg::SOC_NORMAL;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cond_reg <= soc_pkg::SOC_NORMAL;
    end else begin
      cond_reg <= cond_next;
    end
  end

  assign cnt_inc = {cond_next == soc_pkg::SOC_BLOCKED && cond_reg != soc_pkg::SOC_BLOCKED,
                    cond_next == soc_pkg::SOC_TRIP && cond_reg != soc_pkg::SOC_TRIP,
                    cond_next == soc_pkg::SOC_START && cond_reg != soc_pkg::SOC_START,
                    fail_ev && is_close_reg, fail_ev && !is_close_reg,
                    start_close, start_open};

  generate
    for (genvar c = 0; c < 7; c++) begin : g_cnt
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          cnt_reg[c] <= '0;
        end else begin
          cnt_reg[c] <= (clr_stats ? 16'h0 : cnt_reg[c]) + {15'h0, cnt_inc[c]};
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Operation records
  // ----------------------------------------
  soc_pkg::soc_rec_t rec_mem [`SOC_NREC];
  soc_pkg::soc_rec_t rec_new;
  logic [3:0] rec_ptr_reg;
  logic [3:0] rec_wr_idx;
  logic rec_ev;

  assign rec_ev = (done_ev && !is_close_reg && mask_reg.op_done) || (done_ev && is_close_reg && mask_reg.cl_done) ||
                  (fail_ev && !is_close_reg && mask_reg.op_fail) || (fail_ev && is_close_reg && mask_reg.cl_fail);
  // Times beyond 16 bits saturate rather than wrap
  assign rec_new = '{close: is_close_reg, fail: fail_ev,
                     time_cyc: (|tmr_reg[31:16]) ? 16'hffff : tmr_reg[15:0]};
  assign rec_wr_idx = clr_rec ? 4'h0 : rec_ptr_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rec_ptr_reg <= '0;
    end else if (rec_ev) begin
      rec_ptr_reg <= (rec_wr_idx == 4'(`SOC_NREC - 1)) ? 4'h0 : rec_wr_idx + 4'h1;
    end else if (clr_rec) begin
      rec_ptr_reg <= '0;
    end
  end

  generate
    for (genvar e = 0; e < `SOC_NREC; e++) begin : g_rec
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          rec_mem[e] <= '0;
        end else if (rec_ev && rec_wr_idx == 4'(e)) begin
          rec_mem[e] <= rec_new;
        end else if (clr_rec) begin
          rec_mem[e] <= '0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Status routing to relays
  // ----------------------------------------
  generate
    for (genvar g = 0; g < 4; g++) begin : g_route
      logic route_on;
      assign route_on = outcfg_reg[g].en && pos_reg == outcfg_reg[g].pos;
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_relay[g] <= 1'b0;
        end else if (outcfg_reg[g].latch) begin
          o_relay[g] <= route_on || (o_relay[g] && !clr_lat);
        end else begin
          o_relay[g] <= route_on;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [31:0] rdata_next;
  logic [7:0] rec_off;

  assign rec_off = i_addr - `SOC_A_REC;

  always_comb begin
    rdata_next = '0;
    if (i_addr >= `SOC_A_REC && rec_off[7:2] < 6'(`SOC_NREC)) begin
      rdata_next = 32'(rec_mem[rec_off[5:2]]);
    end else begin
      unique case (i_addr)
        `SOC_A_CTRL: rdata_next = 32'(ctrl_reg);
        `SOC_A_SEL0: rdata_next = 32'(sel0_reg);
        `SOC_A_SEL1: rdata_next = 32'(sel1_reg);
        `SOC_A_MASK: rdata_next = 32'(mask_reg);
        `SOC_A_OUTCFG: rdata_next = 32'(outcfg_reg);
        `SOC_A_TRAV: rdata_next = trav_reg;
        `SOC_A_PULSE: rdata_next = pulse_reg;
        `SOC_A_TMO: rdata_next = tmo_reg;
        `SOC_A_STAT: rdata_next = {22'h0, rack_reg, cond_reg, o_fail, o_close_cmd, o_open_cmd, busy, pos_reg};
        `SOC_A_RQCNT: rdata_next = {cnt_reg[1], cnt_reg[0]};
        `SOC_A_FLCNT: rdata_next = {cnt_reg[3], cnt_reg[2]};
        `SOC_A_FNCNT0: rdata_next = {cnt_reg[5], cnt_reg[4]};
        `SOC_A_FNCNT1: rdata_next = {16'h0, cnt_reg[6]};
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= i_rd ? rdata_next : 32'h0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [31:0] cmd_len;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_len <= '0;
    end else begin
      cmd_len <= (o_open_cmd || o_close_cmd) ? cmd_len + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_local_bus;
    ctrl_reg.enable && !ctrl_reg.remote && (bus_op || bus_cl) && !i_app_open && !i_app_close &&
    !(di_ok && (di_op_rise || di_cl_rise)) && state_reg == soc_pkg::SOC_IDLE;
  endsequence

  sequence s_close_no_sync;
    req_close && !req_open && ctrl_reg.use_sync && !src[sel0_reg.sync] && state_reg == soc_pkg::SOC_IDLE;
  endsequence

  pos_bad_a: assert property (ctrl_reg.enable && raw_pos == soc_pkg::SOC_POS_BAD |=>
    pos_reg == soc_pkg::SOC_POS_BAD) else $error("both position inputs high not reported Bad");
  local_bus_a: assert property (s_local_bus |=> !o_open_cmd && !o_close_cmd)
    else $error("bus command acted while local");
  sync_lock_a: assert property (s_close_no_sync |=> !o_close_cmd)
    else $error("close issued without synchro permission");
  req_count_a: assert property (start_open && !clr_stats |=> cnt_reg[0] == $past(cnt_reg[0]) + 16'h1)
    else $error("open request not counted");
  stat_clear_a: assert property (clr_stats && cnt_inc == '0 |=> cnt_reg[0] == '0 && cnt_reg[3] == '0)
    else $error("statistics not cleared");
  pulse_max_a: assert property (o_open_cmd || o_close_cmd |-> cmd_len < pulse_reg || pulse_reg == '0)
    else $error("command pulse too long");
  timeout_abort_a: assert property (fail_ev |=> o_fail && !o_open_cmd && !o_close_cmd &&
    state_reg == soc_pkg::SOC_IDLE) else $error("timeout did not abort");
  early_end_a: assert property (o_open_cmd && pos_reg == soc_pkg::SOC_POS_OPEN |=> !o_open_cmd)
    else $error("open pulse not ended at position");
  one_req_a: assert property ($rose(o_close_cmd) |-> $past(state_reg) == soc_pkg::SOC_IDLE && !o_open_cmd)
    else $error("request accepted while busy");
  inactive_a: assert property (!ctrl_reg.enable |=> state_reg == soc_pkg::SOC_IDLE &&
    pos_reg == soc_pkg::SOC_POS_INTER) else $error("inactive object still processing");
  mask_off_a: assert property (done_ev && !is_close_reg && !mask_reg.op_done && !clr_rec |=>
    rec_ptr_reg == $past(rec_ptr_reg)) else $error("masked event recorded");

endmodule

// ### include/soc_cfg.svh
// Register map, command bits and default timing for the switchgear object block.
// Assumes a 250 MHz system clock; included by bare name.
`ifndef SOC_CFG_SVH
`define SOC_CFG_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SOC_A_CTRL 8'h00
`define SOC_A_SEL0 8'h04
`define SOC_A_SEL1 8'h08
`define SOC_A_TRAV 8'h0c
`define SOC_A_PULSE 8'h10
`define SOC_A_TMO 8'h14
`define SOC_A_CMD 8'h18
`define SOC_A_STAT 8'h1c
`define SOC_A_RQCNT 8'h20
`define SOC_A_FLCNT 8'h24
`define SOC_A_MASK 8'h28
`define SOC_A_OUTCFG 8'h2c
`define SOC_A_FNCNT0 8'h30
`define SOC_A_FNCNT1 8'h34
`define SOC_A_REC 8'h40
`define SOC_NREC 12

// ----------------------------------------
// Command register bits
// ----------------------------------------
`define SOC_K_OPEN 0
`define SOC_K_CLOSE 1
`define SOC_K_CLRST 2
`define SOC_K_CLRREC 3
`define SOC_K_CLRLAT 4
`define SOC_K_CLRFAIL 5

// ----------------------------------------
// Default timing
// ----------------------------------------
`define SOC_CLK_NS 4
`define SOC_TRAV_NS 4000
`define SOC_PULSE_NS 2000
`define SOC_TMO_NS 16000
`define SOC_TRAV_CYC (32'(`SOC_TRAV_NS / `SOC_CLK_NS))
`define SOC_PULSE_CYC (32'(`SOC_PULSE_NS / `SOC_CLK_NS))
`define SOC_TMO_CYC (32'(`SOC_TMO_NS / `SOC_CLK_NS))

`endif

// ### include/soc_pkg.sv
// Types shared by the switchgear object block.
// Assumes nothing beyond a SystemVerilog compiler.
package soc_pkg;
  typedef enum logic [1:0] {SOC_POS_INTER, SOC_POS_OPEN, SOC_POS_CLOSED, SOC_POS_BAD} soc_pos_t;
  typedef enum logic [1:0] {SOC_GND_DISC, SOC_MOTOR_DISC, SOC_BREAKER, SOC_WD_BREAKER} soc_type_t;
  typedef enum logic [1:0] {SOC_NORMAL, SOC_START, SOC_TRIP, SOC_BLOCKED} soc_cond_t;
  typedef enum logic [1:0] {SOC_IDLE, SOC_PULSE, SOC_WAIT} soc_state_t;

  typedef struct packed {
    logic di_remote;
    logic blk_en;
    soc_type_t obj_type;
    logic use_ready;
    logic use_sync;
    logic remote;
    logic enable;
  } soc_ctrl_t;

  typedef struct packed {
    logic [4:0] ready;
    logic [4:0] sync;
    logic [4:0] rk_out;
    logic [4:0] rk_in;
    logic [4:0] closed;
    logic [4:0] open;
  } soc_sel0_t;

  typedef struct packed {
    logic [4:0] di_close;
    logic [4:0] di_open;
    logic [4:0] block;
  } soc_sel1_t;

  typedef struct packed {
    logic cl_fail;
    logic op_fail;
    logic cl_done;
    logic op_done;
  } soc_mask_t;

  typedef struct packed {
    logic en;
    logic latch;
    soc_pos_t pos;
  } soc_route_t;

  typedef struct packed {
    logic close;
    logic fail;
    logic [15:0] time_cyc;
  } soc_rec_t;
endpackage

// ### verif/soc_breaker_model.sv
// Behavioural switching apparatus: two position contacts driven by open/close coils.
// Assumes the controller's command outputs and shares the controller's clock and reset.
`timescale 1ns/1ps

module soc_breaker_model #(
  parameter int TRAVEL = 3
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_open_cmd,
  input wire logic i_close_cmd,
  input wire logic i_stuck,
  output logic o_open_ct,
  output logic o_closed_ct
);
  // ----------------------------------------
  // Travel
  // ----------------------------------------
  logic closed_reg;
  logic [7:0] cnt_reg;

  // Both contacts released while travelling; stuck mechanism ignores coils
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      closed_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
      if (cnt_reg == 8'h01) begin
        closed_reg <= ~closed_reg;
      end
    end else if (!i_stuck && ((i_close_cmd && !closed_reg) || (i_open_cmd && closed_reg))) begin
      cnt_reg <= 8'(TRAVEL);
    end
  end

  assign o_open_ct = (cnt_reg == 8'h00) && !closed_reg;
  assign o_closed_ct = (cnt_reg == 8'h00) && closed_reg;
endmodule

// ### verif/switchgear_object_control_tb_top.sv
// Self-checking bench for the switchgear object controller.
// Assumes the breaker model on digital inputs 0/1 and a 250 MHz clock.
`timescale 1ns/1ps
`include "soc_cfg.svh"

module switchgear_object_control_tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  typedef struct {logic [1:0] raw; int w; soc_pkg::soc_pos_t exp;} soc_row_t;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:2] din_hi = 6'h00;
  logic [7:0] i_logic = 8'h00;
  logic i_app_open = 1'b0;
  logic i_app_close = 1'b0;
  logic stuck = 1'b0;
  logic open_ct, closed_ct, o_open_cmd, o_close_cmd, o_fail;
  logic [31:0] o_rdata;
  logic [3:0] relay;
  soc_pkg::soc_pos_t o_pos;
  logic [31:0] d;
  int n;
  int n_fail = 0;
  int num_checks = 0;
  soc_row_t rows [6] = '{'{2'h0, 8, soc_pkg::SOC_POS_INTER}, '{2'h3, 8, soc_pkg::SOC_POS_BAD},
    '{2'h1, 8, soc_pkg::SOC_POS_OPEN}, '{2'h2, 8, soc_pkg::SOC_POS_CLOSED},
    '{2'h0, 2, soc_pkg::SOC_POS_CLOSED}, '{2'h0, 8, soc_pkg::SOC_POS_INTER}};

  always #2 i_clk = ~i_clk;

  soc_object_ctrl u_soc_object_ctrl (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_din({din_hi, closed_ct, open_ct}), .i_logic(i_logic),
    .i_stage_start(4'h0), .i_stage_trip(4'h0), .i_stage_block(4'h0), .i_app_open(i_app_open),
    .i_app_close(i_app_close), .o_rdata(o_rdata), .o_open_cmd(o_open_cmd), .o_close_cmd(o_close_cmd),
    .o_relay(relay), .o_fail(o_fail), .o_pos(o_pos));

  soc_breaker_model u_soc_breaker_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_open_cmd(o_open_cmd),
    .i_close_cmd(o_close_cmd), .i_stuck(stuck), .o_open_ct(open_ct), .o_closed_ct(closed_ct));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask

  task automatic app(input logic cl);
    @(posedge i_clk);
    if (cl) i_app_close <= 1'b1;
    else i_app_open <= 1'b1;
    @(posedge i_clk);
    i_app_close <= 1'b0;
    i_app_open <= 1'b0;
  endtask

  // Counts command cycles over a fixed window wider than any pulse
  // Starts sampling in the cycle right after the accepting edge
  task automatic pw(input logic cl, output int cnt);
    cnt = 0;
    repeat (40) begin
      #1 if (cl ? o_close_cmd : o_open_cmd) cnt++;
      @(posedge i_clk);
    end
  endtask

  task automatic results();
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    results();
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(`SOC_A_CTRL, d); chk(d, 32'h20);
    rd(`SOC_A_MASK, d); chk(d, 32'h0);
    app(1'b1); pw(1'b1, n); chk(n, 0);
    wr(`SOC_A_TRAV, 32'h4);
    wr(`SOC_A_SEL0, 32'h128);
    wr(`SOC_A_CTRL, 32'h21);
    foreach (rows[i]) begin
      @(posedge i_clk);
      i_logic[1:0] <= rows[i].raw;
      repeat (rows[i].w) @(posedge i_clk);
      #1 chk({30'h0, o_pos}, {30'h0, rows[i].exp});
    end
    wr(`SOC_A_SEL0, 32'h00200020);
    wr(`SOC_A_PULSE, 32'h14);
    wr(`SOC_A_TMO, 32'ha);
    wr(`SOC_A_MASK, 32'hf);
    app(1'b1); pw(1'b1, n); chk(n > 0 && n < 20, 1);
    stuck <= 1'b1;
    wr(`SOC_A_PULSE, 32'h3);
    app(1'b0); pw(1'b0, n); chk(n, 3);
    chk(o_fail, 1'b1);
    rd(`SOC_A_FLCNT, d); chk(d, 32'h1);
    rd(`SOC_A_RQCNT, d); chk(d, 32'h00010001);
    rd(`SOC_A_REC, d); chk(d[17:16], 2'h2);
    rd(`SOC_A_REC + 8'h04, d); chk(d[17:16], 2'h1);
    wr(`SOC_A_CMD, 32'h2c);
    rd(`SOC_A_RQCNT, d); chk(d, 32'h0);
    rd(`SOC_A_FLCNT, d); chk(d, 32'h0);
    rd(`SOC_A_REC, d); chk(d, 32'h0);
    stuck <= 1'b0;
    wr(`SOC_A_CMD, 32'h1); pw(1'b0, n); chk(n, 0);
    wr(`SOC_A_CTRL, 32'h27);
    wr(`SOC_A_CMD, 32'h1); pw(1'b0, n); chk(n > 0, 1);
    wr(`SOC_A_CMD, 32'h2); pw(1'b1, n); chk(n, 0);
    din_hi[2] <= 1'b1;
    wr(`SOC_A_CMD, 32'h2);
    app(1'b0); pw(1'b1, n); chk(n > 0, 1);
    rd(`SOC_A_RQCNT, d); chk(d, 32'h00010001);
    wr(`SOC_A_SEL1, 32'h3);
    wr(`SOC_A_CTRL, 32'h67);
    din_hi[3] <= 1'b1;
    app(1'b0); pw(1'b0, n); chk(n, 0);
    chk({30'h0, o_pos}, {30'h0, soc_pkg::SOC_POS_CLOSED});
    wr(`SOC_A_OUTCFG, 32'hea);
    repeat (2) @(posedge i_clk);
    #1 chk(relay[1:0], 2'h3);
    @(posedge i_clk);
    din_hi[3] <= 1'b0;
    app(1'b0); pw(1'b0, n); chk(relay[1:0], 2'h2);
    wr(`SOC_A_CMD, 32'h10);
    @(posedge i_clk);
    #1 chk(relay[1:0], 2'h0);
    results();
  end
endmodule
